// ### hdl/awss_core.sv
// Arbitrary waveform store and select command logic
`timescale 1ns/1ps
// What this block does
// RULE1: Trigger-source query answers immediate, external or bus, as currently configured.
// RULE2: Downloads carry 8 to 16000 points; any count in range is accepted.
// RULE3: Float samples -1..+1 map onto the negative and positive output peaks.
// RULE4: Integer samples -2047..+2047 are 12-bit converter codes, extremes at peaks.
// RULE5: Integer download takes a binary block or a decimal value list.
// RULE6: Host sets byte order before sending binary integer data.
// RULE7: A new download replaces the volatile waveform without error.
// RULE8: At most four user waveforms besides volatile and built-in entries.
// RULE9: Select picks built-in, user or volatile entry; volatile keyword has no short form.
// RULE10: Selecting never changes output; only the function command starts the arb.
// RULE11: Selecting a name that is not stored is rejected with error 785.
// RULE12: Names up to 8 chars, letter first, then letters, digits, underscore; longer gives 783.
// RULE13: Name characters are converted to upper case before storing or comparing.
// RULE14: Catalog lists built-ins, volatile only if loaded, then stored user names.
// RULE15: Select query returns the active entry: built-in, volatile or user name.
// RULE16: Offset indicator lights when active waveform mean exceeds two codes from zero.
// RULE17: Function query returns one of seven codes sine to user arbitrary.
// RULE18: Arb allowed in AM, FM, FSK, burst, sweep; noise only as AM/FM modulating wave.
// RULE19: Binary samples are two bytes each; byte count is twice point count.
// RULE20: Normal byte order sends high byte first; swapped sends low byte first.
// RULE21: Out-of-range point count is rejected, volatile unchanged, error logged.
module awss_core (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire awss_pkg::awss_cmd_t cmd,
  output logic resp_valid,
  output awss_pkg::awss_resp_t resp,
  output logic err_valid,
  output logic [15:0] err_code,
  output logic wave_wr_valid,
  output awss_pkg::awss_wave_wr_t wave_wr,
  output logic play_bank,
  output logic copy_valid,
  output logic [1:0] copy_slot,
  output awss_pkg::awss_fn_t out_func,
  output logic [3:0] out_entry,
  output awss_pkg::awss_mod_t mod_mode,
  output logic mod_enable,
  output logic offset_led
);

  typedef enum logic [2:0] {
    AWSS_ST_IDLE = 3'b001,
    AWSS_ST_LOAD = 3'b010,
    AWSS_ST_CAT = 3'b100
  } awss_state_t;

  function automatic logic [7:0] awss_upper(input logic [7:0] c);
    if (c >= 8'h61 && c <= 8'h7A) begin
      return c - 8'h20;
    end
    return c;
  endfunction : awss_upper

  function automatic logic awss_is_letter(input logic [7:0] c);
    return c >= 8'h41 && c <= 8'h5A;
  endfunction : awss_is_letter

  function automatic logic awss_char_ok(input logic [7:0] c, input logic first);
    if (first) begin
      return awss_is_letter(c);
    end
    return awss_is_letter(c) || (c >= 8'h30 && c <= 8'h39) || c == 8'h5F;
  endfunction : awss_char_ok

  function automatic logic awss_in_range(input logic signed [15:0] v);
    return v >= awss_pkg::CODE_MIN && v <= awss_pkg::CODE_MAX;
  endfunction : awss_in_range

  function automatic logic awss_mod_ok(input awss_pkg::awss_mod_t m, input logic modw,
                                       input awss_pkg::awss_fn_t f);
    if (f == awss_pkg::AWSS_FN_DC) begin
      return 1'b0;
    end
    if (f == awss_pkg::AWSS_FN_NOISE) begin
      return modw && (m == awss_pkg::AWSS_MOD_AM || m == awss_pkg::AWSS_MOD_FM);
    end
    return 1'b1;
  endfunction : awss_mod_ok

  // |sum| > 2 * count
  function automatic logic awss_offset(input logic signed [25:0] s, input logic [14:0] n);
    logic [25:0] mag;
    mag = s[25] ? 26'(-s) : 26'(s);
    return mag > 26'(n) * 26'(awss_pkg::OFFSET_LIMIT);
  endfunction : awss_offset

  awss_state_t state_reg;
  awss_pkg::awss_trig_t trig_reg;
  logic swap_reg;
  awss_pkg::awss_fmt_t fmt_reg;
  logic [14:0] cnt_reg;
  logic signed [25:0] acc_reg;
  logic load_bad_reg;
  logic range_bad_reg;
  logic half_reg;
  logic [7:0] first_byte_reg;
  logic vol_valid_reg;
  logic signed [25:0] vol_sum_reg;
  logic [14:0] vol_cnt_reg;
  logic [7:0] name_reg [awss_pkg::NAME_CHARS];
  logic [3:0] name_len_reg;
  logic name_long_reg;
  logic name_bad_reg;
  logic [awss_pkg::USER_SLOTS-1:0] user_valid_reg;
  logic [8*awss_pkg::NAME_CHARS-1:0] user_name_reg [awss_pkg::USER_SLOTS];
  logic signed [25:0] user_sum_reg [awss_pkg::USER_SLOTS];
  logic [14:0] user_cnt_reg [awss_pkg::USER_SLOTS];
  logic [3:0] sel_reg;
  logic [3:0] cat_idx_reg;

  logic take;
  logic [8*awss_pkg::NAME_CHARS-1:0] name_flat;
  logic name_hit;
  logic [1:0] hit_slot;
  logic free_any;
  logic [1:0] free_slot;
  logic signed [15:0] sample;
  logic sample_strobe;
  logic [15:0] byte_word;
  logic [31:0] float_prod;
  logic [1:0] sel_user_idx;
  logic [3:0] sel_next;
  logic [15:0] err_next;
  logic entry_present;

  assign take = cmd_valid && cmd_ready;
  assign cmd_ready = state_reg != AWSS_ST_CAT;
  assign play_bank = ~wave_wr.bank;
  assign out_entry = sel_reg;

  always_comb begin
    for (int i = 0; i < awss_pkg::NAME_CHARS; i++) begin
      name_flat[8*(awss_pkg::NAME_CHARS-1-i) +: 8] = name_reg[i];
    end
  end

  // Name lookup among stored user entries, and a free slot for copies
  always_comb begin
    name_hit = 1'b0;
    hit_slot = 2'h0;
    free_any = 1'b0;
    free_slot = 2'h0;
    for (int i = awss_pkg::USER_SLOTS - 1; i >= 0; i--) begin
      if (user_valid_reg[i] && user_name_reg[i] == name_flat) begin
        name_hit = 1'b1;
        hit_slot = 2'(i);
      end
      if (!user_valid_reg[i]) begin
        free_any = 1'b1;
        free_slot = 2'(i);
      end
    end
  end

  // Sample assembly from list values, float values or byte pairs
  always_comb begin
    float_prod = 32'(signed'(cmd.arg)) * 32'(signed'(awss_pkg::CODE_MAX));
    byte_word = swap_reg ? {cmd.arg[7:0], first_byte_reg} : {first_byte_reg, cmd.arg[7:0]};
    sample = 16'(signed'(cmd.arg));
    sample_strobe = 1'b0;
    if (take && state_reg == AWSS_ST_LOAD) begin
      if (cmd.op == awss_pkg::AWSS_OP_LOAD_VALUE && fmt_reg == awss_pkg::AWSS_FMT_FLOAT) begin
        sample = 16'(signed'(float_prod) >>> awss_pkg::FLOAT_FRAC); // RULE3
        sample_strobe = 1'b1;
      end else if (cmd.op == awss_pkg::AWSS_OP_LOAD_VALUE &&
                   fmt_reg == awss_pkg::AWSS_FMT_INT_LIST) begin
        sample_strobe = 1'b1; // RULE5
      end else if (cmd.op == awss_pkg::AWSS_OP_LOAD_BYTE &&
                   fmt_reg == awss_pkg::AWSS_FMT_INT_BLOCK && half_reg) begin
        sample = signed'(byte_word); // RULE19 RULE20
        sample_strobe = 1'b1; // RULE5
      end
    end
  end

  always_comb begin
    sel_next = sel_reg;
    if (cmd.arg[3:0] == awss_pkg::ENTRY_BY_NAME) begin
      sel_next = awss_pkg::ENTRY_USER0 + 4'(hit_slot);
    end else if (cmd.arg[3:0] < awss_pkg::ENTRY_USER0) begin
      sel_next = cmd.arg[3:0];
    end
  end

  // Error decision for the command being taken
  always_comb begin
    err_next = 16'h0000;
    if (take) begin
      unique case (cmd.op)
        awss_pkg::AWSS_OP_LOAD_END: begin
          if (state_reg == AWSS_ST_LOAD && (load_bad_reg || half_reg ||
              cnt_reg < awss_pkg::MIN_POINTS || cnt_reg > awss_pkg::MAX_POINTS)) begin
            err_next = awss_pkg::ERR_POINT_COUNT; // RULE21
          end else if (state_reg == AWSS_ST_LOAD && range_bad_reg) begin
            err_next = awss_pkg::ERR_DATA_RANGE; // RULE4
          end
        end
        awss_pkg::AWSS_OP_SELECT: begin
          if (cmd.arg[3:0] == awss_pkg::ENTRY_BY_NAME && name_long_reg) begin
            err_next = awss_pkg::ERR_NAME_TOO_LONG; // RULE12
          end else if (cmd.arg[3:0] == awss_pkg::ENTRY_BY_NAME && !name_hit) begin
            err_next = awss_pkg::ERR_NO_SUCH_WAVE; // RULE11
          end else if (cmd.arg[3:0] == awss_pkg::ENTRY_VOLATILE && !vol_valid_reg) begin
            err_next = awss_pkg::ERR_NO_SUCH_WAVE; // RULE11
          end else if (cmd.arg[3:0] > awss_pkg::ENTRY_VOLATILE &&
                       cmd.arg[3:0] != awss_pkg::ENTRY_BY_NAME) begin
            err_next = awss_pkg::ERR_NO_SUCH_WAVE;
          end
        end
        awss_pkg::AWSS_OP_COPY: begin
          if (name_long_reg) begin
            err_next = awss_pkg::ERR_NAME_TOO_LONG; // RULE12
          end else if (name_bad_reg || name_len_reg == 4'h0) begin
            err_next = awss_pkg::ERR_NAME_SYNTAX; // RULE12
          end else if (!vol_valid_reg) begin
            err_next = awss_pkg::ERR_NO_SUCH_WAVE;
          end else if (!name_hit && !free_any) begin
            err_next = awss_pkg::ERR_MEM_FULL; // RULE8
          end
        end
        awss_pkg::AWSS_OP_MOD_SET: begin
          if (!awss_mod_ok(awss_pkg::awss_mod_t'(cmd.arg[2:0]), cmd.arg[3],
                           awss_pkg::awss_fn_t'(cmd.arg[6:4]))) begin
            err_next = awss_pkg::ERR_MOD_ILLEGAL; // RULE18
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      err_valid <= 1'b0;
      err_code <= 16'h0000;
    end else begin
      err_valid <= err_next != 16'h0000;
      err_code <= err_next;
    end
  end

  // Settings: trigger source, byte order, function, modulation
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trig_reg <= awss_pkg::AWSS_TRIG_IMMEDIATE;
      swap_reg <= 1'b0;
      out_func <= awss_pkg::AWSS_FN_SINE;
      mod_mode <= awss_pkg::AWSS_MOD_AM;
      mod_enable <= 1'b0;
    end else if (take) begin
      if (cmd.op == awss_pkg::AWSS_OP_TRIG_SET && cmd.arg[1:0] != 2'h3) begin
        trig_reg <= awss_pkg::awss_trig_t'(cmd.arg[1:0]);
      end
      if (cmd.op == awss_pkg::AWSS_OP_BORD_SET) begin
        swap_reg <= cmd.arg[0]; // RULE6
      end
      if (cmd.op == awss_pkg::AWSS_OP_FUNC_SET && cmd.arg[2:0] <= awss_pkg::AWSS_FN_USER) begin
        out_func <= awss_pkg::awss_fn_t'(cmd.arg[2:0]); // RULE10
      end
      if (cmd.op == awss_pkg::AWSS_OP_MOD_SET && err_next == 16'h0000) begin
        mod_mode <= awss_pkg::awss_mod_t'(cmd.arg[2:0]);
        mod_enable <= cmd.arg[7];
      end
    end
  end

  // Download sequencing into the spare bank
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fmt_reg <= awss_pkg::AWSS_FMT_FLOAT;
      cnt_reg <= 15'h0000;
      acc_reg <= 26'sh0000000;
      load_bad_reg <= 1'b0;
      range_bad_reg <= 1'b0;
      half_reg <= 1'b0;
      first_byte_reg <= 8'h00;
      wave_wr_valid <= 1'b0;
      wave_wr <= '0;
      vol_valid_reg <= 1'b0;
      vol_sum_reg <= 26'sh0000000;
      vol_cnt_reg <= 15'h0000;
    end else begin
      wave_wr_valid <= 1'b0;
      if (take && cmd.op == awss_pkg::AWSS_OP_LOAD_BEGIN) begin
        fmt_reg <= awss_pkg::awss_fmt_t'(cmd.arg[1:0]);
        cnt_reg <= 15'h0000;
        acc_reg <= 26'sh0000000;
        load_bad_reg <= cmd.arg[1:0] == 2'h3;
        range_bad_reg <= 1'b0;
        half_reg <= 1'b0;
      end
      if (take && state_reg == AWSS_ST_LOAD && cmd.op == awss_pkg::AWSS_OP_LOAD_BYTE) begin
        half_reg <= ~half_reg;
        first_byte_reg <= cmd.arg[7:0];
      end
      if (sample_strobe) begin
        if (cnt_reg > awss_pkg::MAX_POINTS) begin
          load_bad_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 15'h0001;
        end
        if (!awss_in_range(sample)) begin
          range_bad_reg <= 1'b1; // RULE4
        end
        acc_reg <= acc_reg + 26'(sample);
        wave_wr_valid <= cnt_reg < awss_pkg::MAX_POINTS;
        wave_wr.addr <= cnt_reg[13:0];
        wave_wr.data <= sample[11:0]; // RULE4
      end
      if (take && state_reg == AWSS_ST_LOAD && cmd.op == awss_pkg::AWSS_OP_LOAD_END &&
          err_next == 16'h0000) begin
        wave_wr.bank <= ~wave_wr.bank; // RULE7
        vol_valid_reg <= 1'b1; // RULE2
        vol_sum_reg <= acc_reg;
        vol_cnt_reg <= cnt_reg;
      end
    end
  end

  // Name capture with upper-case folding and syntax check
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      name_reg <= '{default: 8'h00};
      name_len_reg <= 4'h0;
      name_long_reg <= 1'b0;
      name_bad_reg <= 1'b0;
    end else if (take && cmd.op == awss_pkg::AWSS_OP_NAME_CLEAR) begin
      name_reg <= '{default: 8'h00};
      name_len_reg <= 4'h0;
      name_long_reg <= 1'b0;
      name_bad_reg <= 1'b0;
    end else if (take && cmd.op == awss_pkg::AWSS_OP_NAME_CHAR) begin
      if (name_len_reg == 4'(awss_pkg::NAME_CHARS)) begin
        name_long_reg <= 1'b1; // RULE12
      end else begin
        name_reg[name_len_reg[2:0]] <= awss_upper(cmd.arg[7:0]); // RULE13
        name_len_reg <= name_len_reg + 4'h1;
        if (!awss_char_ok(awss_upper(cmd.arg[7:0]), name_len_reg == 4'h0)) begin
          name_bad_reg <= 1'b1; // RULE12
        end
      end
    end
  end

  // User table and waveform selection
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      user_valid_reg <= '0;
      user_name_reg <= '{default: '0};
      user_sum_reg <= '{default: '0};
      user_cnt_reg <= '{default: '0};
      sel_reg <= 4'h0;
      copy_valid <= 1'b0;
      copy_slot <= 2'h0;
    end else begin
      copy_valid <= 1'b0;
      if (take && cmd.op == awss_pkg::AWSS_OP_COPY && err_next == 16'h0000) begin
        copy_valid <= 1'b1;
        copy_slot <= name_hit ? hit_slot : free_slot; // RULE8
        user_valid_reg[name_hit ? hit_slot : free_slot] <= 1'b1;
        user_name_reg[name_hit ? hit_slot : free_slot] <= name_flat;
        user_sum_reg[name_hit ? hit_slot : free_slot] <= vol_sum_reg;
        user_cnt_reg[name_hit ? hit_slot : free_slot] <= vol_cnt_reg;
      end
      if (take && cmd.op == awss_pkg::AWSS_OP_SELECT && err_next == 16'h0000) begin
        sel_reg <= sel_next; // RULE9
      end
    end
  end

  // Offset indicator from the mean of the selected entry
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      offset_led <= 1'b0;
    end else if (sel_reg < awss_pkg::ENTRY_VOLATILE) begin
      offset_led <= awss_pkg::BUILTIN_OFFSET[sel_reg[2:0]];
    end else if (sel_reg == awss_pkg::ENTRY_VOLATILE) begin
      offset_led <= awss_offset(vol_sum_reg, vol_cnt_reg); // RULE16
    end else begin
      offset_led <= awss_offset(user_sum_reg[sel_user_idx], user_cnt_reg[sel_user_idx]); // RULE16
    end
  end

  assign sel_user_idx = 2'(sel_reg - awss_pkg::ENTRY_USER0);

  always_comb begin
    entry_present = 1'b1;
    if (cat_idx_reg == awss_pkg::ENTRY_VOLATILE) begin
      entry_present = vol_valid_reg;
    end else if (cat_idx_reg >= awss_pkg::ENTRY_USER0) begin
      entry_present = user_valid_reg[2'(cat_idx_reg - awss_pkg::ENTRY_USER0)];
    end
  end

  // Command state and query answers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= AWSS_ST_IDLE;
      cat_idx_reg <= 4'h0;
      resp_valid <= 1'b0;
      resp <= '0;
    end else begin
      resp_valid <= 1'b0;
      unique case (state_reg)
        AWSS_ST_IDLE, AWSS_ST_LOAD: begin
          if (take && cmd.op == awss_pkg::AWSS_OP_LOAD_BEGIN) begin
            state_reg <= AWSS_ST_LOAD;
          end else if (take && cmd.op == awss_pkg::AWSS_OP_LOAD_END) begin
            state_reg <= AWSS_ST_IDLE;
          end else if (take && cmd.op == awss_pkg::AWSS_OP_CAT_QRY) begin
            state_reg <= AWSS_ST_CAT;
            cat_idx_reg <= 4'h0;
          end
          if (take && cmd.op == awss_pkg::AWSS_OP_TRIG_QRY) begin
            resp_valid <= 1'b1;
            resp <= '{kind: awss_pkg::AWSS_RSP_TRIG, entry: 4'h0, name: '0,
                      code: {1'b0, trig_reg}}; // RULE1
          end else if (take && cmd.op == awss_pkg::AWSS_OP_FUNC_QRY) begin
            resp_valid <= 1'b1;
            resp <= '{kind: awss_pkg::AWSS_RSP_FUNC, entry: 4'h0, name: '0,
                      code: out_func}; // RULE17
          end else if (take && cmd.op == awss_pkg::AWSS_OP_SELECT_QRY) begin
            resp_valid <= 1'b1;
            resp <= '{kind: awss_pkg::AWSS_RSP_SELECT, entry: sel_reg,
                      name: sel_reg >= awss_pkg::ENTRY_USER0 ? user_name_reg[sel_user_idx] : '0,
                      code: 3'h0}; // RULE15
          end
        end
        AWSS_ST_CAT: begin
          resp_valid <= 1'b1;
          if (cat_idx_reg == 4'(awss_pkg::ENTRY_COUNT)) begin
            resp <= '{kind: awss_pkg::AWSS_RSP_CAT_END, entry: 4'h0, name: '0, code: 3'h0};
            state_reg <= AWSS_ST_IDLE;
          end else begin
            resp_valid <= entry_present; // RULE14
            resp <= '{kind: awss_pkg::AWSS_RSP_CAT_ENTRY, entry: cat_idx_reg,
                      name: cat_idx_reg >= awss_pkg::ENTRY_USER0 ?
                            user_name_reg[2'(cat_idx_reg - awss_pkg::ENTRY_USER0)] : '0,
                      code: 3'h0};
            cat_idx_reg <= cat_idx_reg + 4'h1;
          end
        end
        default: begin
          state_reg <= AWSS_ST_IDLE;
        end
      endcase
    end
  end

endmodule : awss_core

// ### include/awss_pkg.sv
// Constants, opcodes and carrier types of the waveform store block
package awss_pkg;

  localparam int NAME_CHARS = 8;
  localparam int USER_SLOTS = 4;
  localparam int BUILTIN_COUNT = 5;
  localparam int ENTRY_COUNT = 10;
  localparam logic [14:0] MIN_POINTS = 15'h0008;
  localparam logic [14:0] MAX_POINTS = 15'h3E80;
  localparam logic signed [15:0] CODE_MAX = 16'sh07FF;
  localparam logic signed [15:0] CODE_MIN = -16'sh07FF;
  // Float samples arrive as Q2.14: +1.0 is 0x4000
  localparam logic signed [15:0] FLOAT_ONE = 16'sh4000;
  localparam int FLOAT_FRAC = 14;
  localparam logic [13:0] OFFSET_LIMIT = 14'h0002;
  // Built-in entries with an inherent offset; value is arbitrary
  localparam logic [4:0] BUILTIN_OFFSET = 5'h00;

  // Entry numbering: 0..4 built-in, 5 volatile, 6..9 user
  localparam logic [3:0] ENTRY_VOLATILE = 4'h5;
  localparam logic [3:0] ENTRY_USER0 = 4'h6;
  localparam logic [3:0] ENTRY_BY_NAME = 4'hF;

  localparam logic [15:0] ERR_NAME_TOO_LONG = 16'h030F;
  localparam logic [15:0] ERR_NO_SUCH_WAVE = 16'h0311;
  localparam logic [15:0] ERR_MEM_FULL = 16'h030D;
  localparam logic [15:0] ERR_POINT_COUNT = 16'hFF26;
  localparam logic [15:0] ERR_DATA_RANGE = 16'hFF22;
  localparam logic [15:0] ERR_NAME_SYNTAX = 16'hFF8D;
  localparam logic [15:0] ERR_MOD_ILLEGAL = 16'hFF25;

  typedef enum logic [3:0] {
    AWSS_OP_TRIG_SET = 4'h0, AWSS_OP_TRIG_QRY = 4'h1, AWSS_OP_BORD_SET = 4'h2,
    AWSS_OP_LOAD_BEGIN = 4'h3, AWSS_OP_LOAD_VALUE = 4'h4, AWSS_OP_LOAD_BYTE = 4'h5,
    AWSS_OP_LOAD_END = 4'h6, AWSS_OP_NAME_CLEAR = 4'h7, AWSS_OP_NAME_CHAR = 4'h8,
    AWSS_OP_SELECT = 4'h9, AWSS_OP_SELECT_QRY = 4'hA, AWSS_OP_CAT_QRY = 4'hB,
    AWSS_OP_FUNC_SET = 4'hC, AWSS_OP_FUNC_QRY = 4'hD, AWSS_OP_COPY = 4'hE,
    AWSS_OP_MOD_SET = 4'hF
  } awss_op_t;

  typedef enum logic [1:0] {
    AWSS_TRIG_IMMEDIATE = 2'h0, AWSS_TRIG_EXTERNAL = 2'h1, AWSS_TRIG_BUS = 2'h2
  } awss_trig_t;

  typedef enum logic [1:0] {
    AWSS_FMT_FLOAT = 2'h0, AWSS_FMT_INT_LIST = 2'h1, AWSS_FMT_INT_BLOCK = 2'h2
  } awss_fmt_t;

  typedef enum logic [2:0] {
    AWSS_FN_SINE = 3'h0, AWSS_FN_SQUARE = 3'h1, AWSS_FN_TRIANGLE = 3'h2,
    AWSS_FN_RAMP = 3'h3, AWSS_FN_NOISE = 3'h4, AWSS_FN_DC = 3'h5, AWSS_FN_USER = 3'h6
  } awss_fn_t;

  typedef enum logic [2:0] {
    AWSS_MOD_AM = 3'h0, AWSS_MOD_FM = 3'h1, AWSS_MOD_FSK = 3'h2,
    AWSS_MOD_BURST = 3'h3, AWSS_MOD_SWEEP = 3'h4
  } awss_mod_t;

  typedef enum logic [2:0] {
    AWSS_RSP_TRIG = 3'h0, AWSS_RSP_FUNC = 3'h1, AWSS_RSP_SELECT = 3'h2,
    AWSS_RSP_CAT_ENTRY = 3'h3, AWSS_RSP_CAT_END = 3'h4
  } awss_rsp_t;

  typedef struct packed {
    awss_op_t op;
    logic [15:0] arg;
  } awss_cmd_t;

  typedef struct packed {
    awss_rsp_t kind;
    logic [3:0] entry;
    logic [8*NAME_CHARS-1:0] name;
    logic [2:0] code;
  } awss_resp_t;

  typedef struct packed {
    logic bank;
    logic [13:0] addr;
    logic [11:0] data;
  } awss_wave_wr_t;

endpackage : awss_pkg

// ### tb/awss_checker_assertions.sv
// Port assertions for the waveform store block
`timescale 1ns/1ps
module awss_checker (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire awss_pkg::awss_cmd_t cmd,
  input wire logic resp_valid,
  input wire awss_pkg::awss_resp_t resp,
  input wire logic wave_wr_valid,
  input wire awss_pkg::awss_wave_wr_t wave_wr,
  input wire logic play_bank,
  input wire awss_pkg::awss_fn_t out_func,
  input wire logic [3:0] out_entry
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire tk = cmd_valid && cmd_ready;
  chk_trig_answer: assert property (tk && cmd.op == awss_pkg::AWSS_OP_TRIG_QRY |=>
    resp_valid && resp.kind == awss_pkg::AWSS_RSP_TRIG && resp.code <= 3'h2)
    else $error("bad trigger answer");
  chk_select_quiet: assert property (tk && cmd.op == awss_pkg::AWSS_OP_SELECT
    |=> $stable(out_func)) else $error("select changed output");
  chk_func_start: assert property (tk && cmd.op == awss_pkg::AWSS_OP_FUNC_SET
    && cmd.arg == 16'h0006 |=> out_func == awss_pkg::AWSS_FN_USER)
    else $error("user function not started");
  chk_code_range: assert property (wave_wr_valid |-> wave_wr.data != 12'h800)
    else $error("sample code out of range");
  chk_bank_cause: assert property ($changed(play_bank)
    |-> $past(tk) && $past(cmd.op) == awss_pkg::AWSS_OP_LOAD_END) else $error("stray bank swap");
  chk_entry_range: assert property (out_entry <= 4'h9) else $error("entry out of range");
  chk_cat_stall: assert property (tk && cmd.op == awss_pkg::AWSS_OP_CAT_QRY
    |=> !cmd_ready) else $error("catalog did not stall");
  chk_select_echo: assert property (resp_valid && resp.kind == awss_pkg::AWSS_RSP_SELECT
    |-> resp.entry == out_entry) else $error("select answer differs");
endmodule : awss_checker

bind awss_core awss_checker awss_checker_i (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd(cmd), .resp_valid(resp_valid), .resp(resp),
  .wave_wr_valid(wave_wr_valid), .wave_wr(wave_wr), .play_bank(play_bank),
  .out_func(out_func), .out_entry(out_entry));

// ### tb/awss_host.sv
// Remote host model: commands and binary byte pairs
`timescale 1ns/1ps
module awss_host (
  input wire logic mclk,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output awss_pkg::awss_cmd_t cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  task automatic send(input awss_pkg::awss_op_t op, input logic [15:0] arg);
    @(negedge mclk);
    cmd_valid <= 1'b1;
    cmd <= '{op, arg};
    while (!cmd_ready) @(negedge mclk);
    @(posedge mclk);
  endtask : send
  task automatic idle();
    @(negedge mclk);
    cmd_valid <= 1'b0;
  endtask : idle
  task automatic block(input logic [15:0] w, input int n, input logic swap);
    send(awss_pkg::AWSS_OP_BORD_SET, {15'h0000, swap});
    send(awss_pkg::AWSS_OP_LOAD_BEGIN, 16'h0002);
    repeat (n) begin
      send(awss_pkg::AWSS_OP_LOAD_BYTE, {8'h00, swap ? w[7:0] : w[15:8]});
      send(awss_pkg::AWSS_OP_LOAD_BYTE, {8'h00, swap ? w[15:8] : w[7:0]});
    end
    send(awss_pkg::AWSS_OP_LOAD_END, 16'h0000);
  endtask : block
endmodule : awss_host

// ### tb/testbench.sv
// Self-checking bench for the waveform store block
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid, cmd_ready, resp_valid, err_valid, wave_wr_valid, play_bank, offset_led, pb;
  awss_pkg::awss_cmd_t cmd;
  awss_pkg::awss_resp_t resp, last_resp;
  awss_pkg::awss_wave_wr_t wave_wr;
  awss_pkg::awss_fn_t out_func;
  logic [15:0] err_code, last_err;
  logic [11:0] last_data;
  logic [3:0] out_entry;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_err, n_wr, n_cat;
  int fm[6] = '{0, 1, 2, 2, 1, 0};
  int np[6] = '{8, 8, 8, 8, 7, 16000};
  always #4 mclk = ~mclk;
  awss_core awss_core_i (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .resp_valid(resp_valid), .resp(resp),
    .err_valid(err_valid), .err_code(err_code), .wave_wr_valid(wave_wr_valid),
    .wave_wr(wave_wr), .play_bank(play_bank), .copy_valid(), .copy_slot(),
    .out_func(out_func), .out_entry(out_entry), .mod_mode(), .mod_enable(),
    .offset_led(offset_led));
  awss_host awss_host_i (.mclk(mclk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd(cmd));
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      stop_test();
    end
    if (err_valid === 1'b1) begin
      n_err++;
      last_err = err_code;
    end
    if (wave_wr_valid === 1'b1) begin
      n_wr++;
      last_data = wave_wr.data;
    end
    if (resp_valid === 1'b1) last_resp = resp;
    if (resp_valid === 1'b1 && resp.kind === awss_pkg::AWSS_RSP_CAT_ENTRY) n_cat++;
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check
  task automatic s(input awss_pkg::awss_op_t op, input logic [15:0] arg);
    awss_host_i.send(op, arg);
  endtask : s
  task automatic settle(input int n);
    awss_host_i.idle();
    repeat (n) @(posedge mclk);
  endtask : settle
  task automatic name(input string t);
    s(awss_pkg::AWSS_OP_NAME_CLEAR, 16'h0000);
    foreach (t[k]) s(awss_pkg::AWSS_OP_NAME_CHAR, {8'h00, t[k]});
  endtask : name
  task automatic t_codes();
    for (int c = 0; c < 7; c++) begin
      if (c < 3) s(awss_pkg::AWSS_OP_TRIG_SET, 16'(c));
      s(awss_pkg::AWSS_OP_TRIG_QRY, 16'h0000);
      settle(3);
      if (c < 3) check(last_resp.code, c, "trigger code");
      s(awss_pkg::AWSS_OP_FUNC_SET, 16'(c));
      s(awss_pkg::AWSS_OP_FUNC_QRY, 16'h0000);
      settle(3);
      check(last_resp.code, c, "function code");
    end
    s(awss_pkg::AWSS_OP_MOD_SET, 16'h0042);
    settle(3);
    check(last_err, awss_pkg::ERR_MOD_ILLEGAL, "modulation");
    $display("test codes done");
  endtask : t_codes
  task automatic t_load();
    for (int i = 0; i < 6; i++) begin
      n_err = 0;
      n_wr = 0;
      pb = play_bank;
      if (fm[i] == 2) awss_host_i.block(16'hF801, np[i], i == 3);
      else begin
        s(awss_pkg::AWSS_OP_LOAD_BEGIN, 16'(fm[i]));
        repeat (np[i]) s(awss_pkg::AWSS_OP_LOAD_VALUE, fm[i] == 0 ? 16'hC000 : 16'hF801);
        s(awss_pkg::AWSS_OP_LOAD_END, 16'h0000);
      end
      settle(3);
      check(play_bank, np[i] >= 8 ? !pb : pb, "bank swap");
      if (np[i] < 8) check(last_err, awss_pkg::ERR_POINT_COUNT, "count error");
      else begin
        check(n_err, 0, "load error");
        check({n_wr, last_data}, {np[i], 12'h801}, "samples");
      end
    end
    $display("test load done");
  endtask : t_load
  task automatic t_select();
    s(awss_pkg::AWSS_OP_FUNC_SET, 16'h0000);
    s(awss_pkg::AWSS_OP_SELECT, 16'h0005);
    s(awss_pkg::AWSS_OP_SELECT_QRY, 16'h0000);
    settle(3);
    check({out_func, last_resp.entry}, 7'h05, "volatile");
    check(offset_led, 1'b1, "volatile offset");
    s(awss_pkg::AWSS_OP_SELECT, 16'h0000);
    s(awss_pkg::AWSS_OP_FUNC_SET, 16'h0006);
    settle(3);
    check({out_func, offset_led}, {3'h6, 1'b0}, "builtin");
    n_err = 0;
    name("arb_1");
    s(awss_pkg::AWSS_OP_COPY, 16'h0000);
    name("ARB_1");
    s(awss_pkg::AWSS_OP_SELECT, 16'h000F);
    s(awss_pkg::AWSS_OP_SELECT_QRY, 16'h0000);
    settle(3);
    check({n_err, last_resp.entry}, {32'h0, 4'h6}, "user name");
    name("nowave");
    s(awss_pkg::AWSS_OP_SELECT, 16'h000F);
    settle(3);
    check(last_err, 16'h0311, "missing name");
    name("toolong_9");
    s(awss_pkg::AWSS_OP_SELECT, 16'h000F);
    settle(3);
    check(last_err, 16'h030F, "long name");
    n_cat = 0;
    s(awss_pkg::AWSS_OP_CAT_QRY, 16'h0000);
    settle(16);
    check(n_cat, 7, "catalog");
    $display("test select done");
  endtask : t_select
  initial begin
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    t_codes();
    t_load();
    t_select();
    stop_test();
  end
endmodule : testbench
